// ---- hdl/timer_two_defs.svh ----
// Offsets, field positions and reset values of the reload timer control
// Assumes inclusion by bare name from the design files
`ifndef TIMER_TWO_DEFS_SVH
`define TIMER_TWO_DEFS_SVH

`define TT_CTRL_ADDR    8'hc8
`define TT_RLL_ADDR     8'hca
`define TT_RLH_ADDR     8'hcb
`define TT_CNTL_ADDR    8'hcc
`define TT_CNTH_ADDR    8'hcd

`define TT_BIT_HOF      7
`define TT_BIT_LOF      6
`define TT_BIT_LIE      5
`define TT_BIT_CEN      4
`define TT_BIT_SPLIT    3
`define TT_BIT_RUN      2
`define TT_BIT_XSEL_HI  1
`define TT_BIT_XSEL_LO  0

`define TT_CTRL_RESET   8'h00
`define TT_BYTE_RESET   8'h00
`define TT_WORD_RESET   16'h0000
`define TT_BYTE_MAX     8'hff
`define TT_WORD_MAX     16'hffff
`define TT_WORD_ONE     16'h0001
`define TT_BYTE_ONE     8'h01

`endif

// ---- hdl/timer_two_pkg.sv ----
// Types shared by the reload timer control files
// Assumes nothing of its surroundings
package timer_two_pkg;

    typedef logic [7:0] sfr_byte_t;
    typedef logic [15:0] count_word_t;

    typedef enum logic {
        MODE_WIDE  = 1'b0,
        MODE_SPLIT = 1'b1
    } timer_mode_t;

endpackage

// ---- hdl/capture_trigger.sv ----
// Capture trigger selection and edge detection
// Assumes oscillator tick and comparator level are synchronous to ref_clk_i
`timescale 1ns/1ps
`default_nettype none

module capture_trigger
    import timer_two_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // Trigger sources
    input  wire logic rtc_div8_tick_i,
    input  wire logic comparator_i,
    input  wire logic trig_sel_cmp_i,
    // Event
    output var  logic capture_evt_o
);

    logic cmp_d_r;
    logic cmp_d_nxt;
    logic evt_r;
    logic evt_nxt;

    // -----------------------------------------------------------------
    // Trigger select
    // -----------------------------------------------------------------
    always_comb begin
        cmp_d_nxt = comparator_i;
        if (trig_sel_cmp_i) begin
            evt_nxt = comparator_i && !cmp_d_r;
        end else begin
            evt_nxt = rtc_div8_tick_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cmp_d_r <= 1'b0;
            evt_r   <= 1'b0;
        end else begin
            cmp_d_r <= cmp_d_nxt;
            evt_r   <= evt_nxt;
        end
    end

    assign capture_evt_o = evt_r;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    chk_trigger_cmp_edge: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        trig_sel_cmp_i && comparator_i && !cmp_d_r |=> capture_evt_o)
        else $error("comparator edge gave no capture event");

    chk_trigger_rtc_tick: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !trig_sel_cmp_i && !rtc_div8_tick_i |=> !capture_evt_o)
        else $error("capture event without oscillator tick");

endmodule

`default_nettype wire

// ---- hdl/timer_two_ctrl.sv ----
// Control, status, counter and reload logic of the 16-bit reload timer
// Assumes clock-source ticks are selected outside and are synchronous
//
// Operation
// - Upper byte rolling from 0xFF to 0x00 sets the high overflow flag.
// - In combined mode a 0xFFFF to 0x0000 wrap sets the high flag.
// - Enabled timer interrupt plus set high flag raises the request.
// - Flags are cleared only by software writing zero.
// - Every lower byte rollover sets the low flag in either mode.
// - Low-byte enable plus timer enable requests on lower overflow.
// - Capture enable bit one selects capture mode, zero disables it.
// - Control register at 0xC8, bit addressable, resets to zero.
// - Split bit one gives two 8-bit timers, zero one 16-bit timer.
// - Run bit gates counting; in split mode only the upper byte.
// - Upper select bit chooses oscillator (0) or comparator (1) capture trigger.
// - Capture copies live count to reload registers, sets high flag.
`timescale 1ns/1ps
`default_nettype none
`include "timer_two_defs.svh"

module timer_two_ctrl
    import timer_two_pkg::*;
#(
    parameter int BYTE_W = 8
)(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Special function register bus
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    input  wire logic        sfr_bit_wr_i,
    input  wire logic [2:0]  sfr_bit_sel_i,
    input  wire logic        sfr_bit_val_i,
    input  wire logic        sfr_rd_i,
    output var  logic [7:0]  sfr_rdata_o,
    // Count ticks and interrupt enable
    input  wire logic        tick_low_i,
    input  wire logic        tick_high_i,
    input  wire logic        timer_irq_en_i,
    // Capture sources
    input  wire logic        rtc_div8_tick_i,
    input  wire logic        comparator_i,
    // Status and control outputs
    output var  logic        irq_o,
    output var  logic [1:0]  ext_clk_sel_o,
    output var  logic [15:0] count_o
);

    if (BYTE_W != 8) begin : bad_width_check
        $error("timer_two_ctrl serves only an 8-bit register bus");
    end

    sfr_byte_t   ctrl_r;
    sfr_byte_t   ctrl_nxt;
    sfr_byte_t   ctrl_wr;
    count_word_t cnt_r;
    count_word_t cnt_nxt;
    count_word_t rl_r;
    count_word_t rl_nxt;
    sfr_byte_t   rdata_r;
    sfr_byte_t   rdata_nxt;
    logic        irq_r;
    logic        irq_nxt;
    logic        hof_set;
    logic        lof_set;
    logic        cap_evt;
    logic        ctrl_hit;
    logic        ctrl_bit_hit;
    timer_mode_t mode;
    logic        run;
    logic        cen;

    assign mode         = timer_mode_t'(ctrl_r[`TT_BIT_SPLIT]);
    assign run          = ctrl_r[`TT_BIT_RUN];
    assign cen          = ctrl_r[`TT_BIT_CEN];
    assign ctrl_hit     = sfr_wr_i && (sfr_addr_i == `TT_CTRL_ADDR);
    assign ctrl_bit_hit = sfr_bit_wr_i && (sfr_addr_i == `TT_CTRL_ADDR);

    // -----------------------------------------------------------------
    // Capture trigger
    // -----------------------------------------------------------------
    capture_trigger u_trig (
        .ref_clk_i       (ref_clk_i),
        .rst_i           (rst_i),
        .rtc_div8_tick_i (rtc_div8_tick_i),
        .comparator_i    (comparator_i),
        .trig_sel_cmp_i  (ctrl_r[`TT_BIT_XSEL_HI]),
        .capture_evt_o   (cap_evt)
    );

    // -----------------------------------------------------------------
    // Counter, reload and flags
    // -----------------------------------------------------------------
    always_comb begin
        cnt_nxt = cnt_r;
        rl_nxt  = rl_r;
        hof_set = 1'b0;
        lof_set = 1'b0;
        unique case (mode)
            MODE_WIDE: begin
                if (run && tick_low_i) begin
                    if (cnt_r == `TT_WORD_MAX) begin
                        hof_set = 1'b1;
                        lof_set = 1'b1;
                        cnt_nxt = cen ? `TT_WORD_RESET : rl_r;
                    end else begin
                        cnt_nxt = cnt_r + `TT_WORD_ONE;
                        lof_set = (cnt_r[7:0] == `TT_BYTE_MAX);
                    end
                end
            end
            MODE_SPLIT: begin
                if (tick_low_i) begin
                    if (cnt_r[7:0] == `TT_BYTE_MAX) begin
                        lof_set      = 1'b1;
                        cnt_nxt[7:0] = rl_r[7:0];
                    end else begin
                        cnt_nxt[7:0] = cnt_r[7:0] + `TT_BYTE_ONE;
                    end
                end
                if (run && tick_high_i) begin
                    if (cnt_r[15:8] == `TT_BYTE_MAX) begin
                        hof_set       = 1'b1;
                        cnt_nxt[15:8] = rl_r[15:8];
                    end else begin
                        cnt_nxt[15:8] = cnt_r[15:8] + `TT_BYTE_ONE;
                    end
                end
            end
        endcase
        if (cen && cap_evt) begin
            rl_nxt  = cnt_r;
            hof_set = 1'b1;
        end
        if (sfr_wr_i) begin
            unique case (sfr_addr_i)
                `TT_RLL_ADDR:  rl_nxt[7:0]   = sfr_wdata_i;
                `TT_RLH_ADDR:  rl_nxt[15:8]  = sfr_wdata_i;
                `TT_CNTL_ADDR: cnt_nxt[7:0]  = sfr_wdata_i;
                `TT_CNTH_ADDR: cnt_nxt[15:8] = sfr_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Control register and interrupt request
    // -----------------------------------------------------------------
    always_comb begin
        ctrl_wr = ctrl_r;
        if (ctrl_hit) begin
            ctrl_wr = sfr_wdata_i;
        end else if (ctrl_bit_hit) begin
            ctrl_wr[sfr_bit_sel_i] = sfr_bit_val_i;
        end
        ctrl_nxt = ctrl_wr;
        ctrl_nxt[`TT_BIT_HOF] = ctrl_wr[`TT_BIT_HOF] || hof_set;
        ctrl_nxt[`TT_BIT_LOF] = ctrl_wr[`TT_BIT_LOF] || lof_set;
        irq_nxt = timer_irq_en_i && (ctrl_r[`TT_BIT_HOF]
            || (ctrl_r[`TT_BIT_LOF] && ctrl_r[`TT_BIT_LIE]));
    end

    // -----------------------------------------------------------------
    // Read data
    // -----------------------------------------------------------------
    always_comb begin
        rdata_nxt = rdata_r;
        if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                `TT_CTRL_ADDR: rdata_nxt = ctrl_r;
                `TT_RLL_ADDR:  rdata_nxt = rl_r[7:0];
                `TT_RLH_ADDR:  rdata_nxt = rl_r[15:8];
                `TT_CNTL_ADDR: rdata_nxt = cnt_r[7:0];
                `TT_CNTH_ADDR: rdata_nxt = cnt_r[15:8];
                default:       rdata_nxt = `TT_BYTE_RESET;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_r  <= `TT_CTRL_RESET;
            cnt_r   <= `TT_WORD_RESET;
            rl_r    <= `TT_WORD_RESET;
            rdata_r <= `TT_BYTE_RESET;
            irq_r   <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            cnt_r   <= cnt_nxt;
            rl_r    <= rl_nxt;
            rdata_r <= rdata_nxt;
            irq_r   <= irq_nxt;
        end
    end

    assign sfr_rdata_o   = rdata_r;
    assign irq_o         = irq_r;
    assign ext_clk_sel_o = ctrl_r[`TT_BIT_XSEL_HI:`TT_BIT_XSEL_LO];
    assign count_o       = cnt_r;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    logic no_wr;
    assign no_wr = !sfr_wr_i && !sfr_bit_wr_i;

    chk_split_high_flag: assert property (
        no_wr && mode == MODE_SPLIT && run && tick_high_i
        && cnt_r[15:8] == `TT_BYTE_MAX
        |=> ctrl_r[`TT_BIT_HOF] && cnt_r[15:8] == $past(rl_r[15:8]))
        else $error("upper byte rollover missed");

    chk_wide_wrap_flag: assert property (
        no_wr && mode == MODE_WIDE && run && tick_low_i && !cen
        && cnt_r == `TT_WORD_MAX
        |=> ctrl_r[`TT_BIT_HOF] && cnt_r == $past(rl_r))
        else $error("16-bit wrap missed");

    chk_irq_high_flag: assert property (
        timer_irq_en_i && ctrl_r[`TT_BIT_HOF] |=> irq_o)
        else $error("high flag gave no request");

    chk_flags_sticky: assert property (
        no_wr && ctrl_r[`TT_BIT_HOF] && ctrl_r[`TT_BIT_LOF]
        |=> ctrl_r[`TT_BIT_HOF] && ctrl_r[`TT_BIT_LOF])
        else $error("flag cleared by hardware");

    chk_low_flag_set: assert property (
        no_wr && tick_low_i && cnt_r[7:0] == `TT_BYTE_MAX
        && (run || mode == MODE_SPLIT) |=> ctrl_r[`TT_BIT_LOF])
        else $error("low byte rollover missed");

    chk_irq_low_path: assert property (
        !timer_irq_en_i ##1 !timer_irq_en_i |=> !irq_o)
        else $error("request without timer enable");

    chk_capture_off: assert property (
        no_wr && !cen |=> rl_r == $past(rl_r))
        else $error("reload changed outside capture mode");

    chk_reset_zero: assert property (
        @(posedge ref_clk_i) disable iff (1'b0)
        rst_i |=> ctrl_r == `TT_CTRL_RESET && !irq_o)
        else $error("control not cleared by reset");

    chk_split_low_free: assert property (
        no_wr && mode == MODE_SPLIT && !run && tick_low_i
        && cnt_r[7:0] != `TT_BYTE_MAX
        |=> cnt_r[7:0] == $past(cnt_r[7:0]) + `TT_BYTE_ONE
        && cnt_r[15:8] == $past(cnt_r[15:8]))
        else $error("split low byte did not run freely");

    chk_capture_copy: assert property (
        no_wr && cen && cap_evt
        |=> rl_r == $past(cnt_r) && ctrl_r[`TT_BIT_HOF])
        else $error("capture did not copy count");

    chk_irq_low_flag: assert property (
        timer_irq_en_i && ctrl_r[`TT_BIT_LOF] && ctrl_r[`TT_BIT_LIE]
        |=> irq_o)
        else $error("low flag gave no request");

    cov_wide_wrap: cover property (
        mode == MODE_WIDE && run && tick_low_i && cnt_r == `TT_WORD_MAX);
    cov_split_both: cover property (
        mode == MODE_SPLIT && hof_set && lof_set);
    cov_capture: cover property (cen && cap_evt ##2 irq_o);

endmodule

`default_nettype wire

// ---- dv/sfr_host.sv ----
// Processor-core side of the special function register bus
// Assumes the control block samples strobes on rising edges of ref_clk_i
`timescale 1ns/1ps
`default_nettype none

module sfr_host
    import timer_two_pkg::*;
(
    // Clock
    input  wire logic       ref_clk_i,
    // Bus towards the block
    output var  logic [7:0] addr_o,
    output var  logic       wr_o,
    output var  logic [7:0] wdata_o,
    output var  logic       bit_wr_o,
    output var  logic [2:0] bit_sel_o,
    output var  logic       bit_val_o,
    output var  logic       rd_o,
    input  wire logic [7:0] rdata_i
);
    initial begin
        addr_o    = 8'h00;
        wr_o      = 1'b0;
        wdata_o   = 8'h00;
        bit_wr_o  = 1'b0;
        bit_sel_o = 3'h0;
        bit_val_o = 1'b0;
        rd_o      = 1'b0;
    end

    // Byte write, one strobe cycle; writing zero clears a flag
    task automatic wr_byte(input sfr_byte_t a, input sfr_byte_t d);
        @(negedge ref_clk_i);
        addr_o  = a;
        wdata_o = d;
        wr_o    = 1'b1;
        @(negedge ref_clk_i);
        wr_o    = 1'b0;
    endtask

    // Single-bit write
    task automatic wr_bit(input sfr_byte_t a, input int n, input logic v);
        @(negedge ref_clk_i);
        addr_o    = a;
        bit_sel_o = 3'(n);
        bit_val_o = v;
        bit_wr_o  = 1'b1;
        @(negedge ref_clk_i);
        bit_wr_o  = 1'b0;
    endtask

    // Read; data is settled one cycle after the strobe
    task automatic rd_byte(input sfr_byte_t a, output sfr_byte_t d);
        @(negedge ref_clk_i);
        addr_o = a;
        rd_o   = 1'b1;
        @(negedge ref_clk_i);
        rd_o   = 1'b0;
        d      = rdata_i;
    endtask
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench of the reload timer control block
// Assumes sfr_host drives the register bus; other inputs driven here
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import timer_two_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr, wdata, rdata;
    logic        wr, bit_wr, bit_val, rd;
    logic [2:0]  bit_sel;
    logic        tick_lo = 1'b0;
    logic        tick_hi = 1'b0;
    logic        irq_en = 1'b0;
    logic        osc_tick = 1'b0;
    logic        cmp = 1'b0;
    logic        irq;
    logic [1:0]  xsel;
    logic [15:0] count;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    initial forever #10 ref_clk_i = ~ref_clk_i;

    sfr_host host_u (.ref_clk_i(ref_clk_i), .addr_o(addr), .wr_o(wr),
        .wdata_o(wdata), .bit_wr_o(bit_wr), .bit_sel_o(bit_sel),
        .bit_val_o(bit_val), .rd_o(rd), .rdata_i(rdata));

    timer_two_ctrl #(.BYTE_W(8)) dut_u (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_wdata_i(wdata), .sfr_bit_wr_i(bit_wr),
        .sfr_bit_sel_i(bit_sel), .sfr_bit_val_i(bit_val), .sfr_rd_i(rd),
        .sfr_rdata_o(rdata), .tick_low_i(tick_lo), .tick_high_i(tick_hi),
        .timer_irq_en_i(irq_en), .rtc_div8_tick_i(osc_tick),
        .comparator_i(cmp), .irq_o(irq), .ext_clk_sel_o(xsel),
        .count_o(count));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check_byte(input sfr_byte_t got, input sfr_byte_t exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_word(input count_word_t got,
                              input count_word_t exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input sfr_byte_t a, input sfr_byte_t exp);
        sfr_byte_t d;
        host_u.rd_byte(a, d);
        check_byte(d, exp);
    endtask

    task automatic pulse(ref logic s);
        @(negedge ref_clk_i);
        s = 1'b1;
        @(negedge ref_clk_i);
        s = 1'b0;
    endtask

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd_chk(8'hc8, 8'h00);
        rd_chk(8'hcd, 8'h00);
        rd_chk(8'hc0, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_bits;
        sfr_byte_t e;
        e = 8'h00;
        for (int i = 0; i < 8; i++) begin
            host_u.wr_bit(8'hc8, i, 1'b1);
            e[i] = 1'b1;
            rd_chk(8'hc8, e);
        end
        check_byte({6'h00, xsel}, 8'h03);
        host_u.wr_bit(8'hc8, 4, 1'b0);
        rd_chk(8'hc8, 8'hef);
        host_u.wr_bit(8'hca, 0, 1'b1);
        rd_chk(8'hca, 8'h00);
        host_u.wr_byte(8'hc8, 8'h00);
        $display("test bits done");
    endtask

    task automatic t_wide;
        host_u.wr_byte(8'hca, 8'h34);
        host_u.wr_byte(8'hcb, 8'h12);
        host_u.wr_byte(8'hcc, 8'hfe);
        host_u.wr_byte(8'hcd, 8'hff);
        host_u.wr_byte(8'hc8, 8'h04);
        irq_en = 1'b1;
        pulse(tick_lo);
        check_word(count, 16'hffff);
        pulse(tick_lo);
        check_word(count, 16'h1234);
        rd_chk(8'hc8, 8'hc4);
        check_byte({7'h00, irq}, 8'h01);
        repeat (10) @(negedge ref_clk_i);
        rd_chk(8'hc8, 8'hc4);
        host_u.wr_bit(8'hc8, 7, 1'b0);
        @(negedge ref_clk_i);
        check_byte({7'h00, irq}, 8'h00);
        host_u.wr_bit(8'hc8, 5, 1'b1);
        @(negedge ref_clk_i);
        check_byte({7'h00, irq}, 8'h01);
        irq_en = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        check_byte({7'h00, irq}, 8'h00);
        host_u.wr_byte(8'hc8, 8'h00);
        pulse(tick_lo);
        check_word(count, 16'h1234);
        $display("test wide done");
    endtask

    task automatic t_split;
        host_u.wr_byte(8'hc8, 8'h08);
        host_u.wr_byte(8'hca, 8'h80);
        host_u.wr_byte(8'hcb, 8'h40);
        host_u.wr_byte(8'hcc, 8'hff);
        host_u.wr_byte(8'hcd, 8'hff);
        irq_en = 1'b1;
        pulse(tick_lo);
        check_word(count, 16'hff80);
        rd_chk(8'hc8, 8'h48);
        pulse(tick_hi);
        check_word(count, 16'hff80);
        pulse(tick_lo);
        check_word(count, 16'hff81);
        host_u.wr_byte(8'hc8, 8'h2c);
        pulse(tick_hi);
        check_word(count, 16'h4081);
        rd_chk(8'hc8, 8'hac);
        check_byte({7'h00, irq}, 8'h01);
        irq_en = 1'b0;
        host_u.wr_byte(8'hc8, 8'h00);
        $display("test split done");
    endtask

    task automatic t_capture;
        host_u.wr_byte(8'hca, 8'h00);
        host_u.wr_byte(8'hcb, 8'h00);
        host_u.wr_byte(8'hcc, 8'h78);
        host_u.wr_byte(8'hcd, 8'h56);
        pulse(osc_tick);
        repeat (2) @(negedge ref_clk_i);
        rd_chk(8'hca, 8'h00);
        host_u.wr_byte(8'hc8, 8'h10);
        irq_en = 1'b1;
        pulse(osc_tick);
        repeat (2) @(negedge ref_clk_i);
        rd_chk(8'hca, 8'h78);
        rd_chk(8'hcb, 8'h56);
        rd_chk(8'hc8, 8'h90);
        check_byte({7'h00, irq}, 8'h01);
        host_u.wr_byte(8'hc8, 8'h12);
        host_u.wr_byte(8'hcc, 8'hbc);
        host_u.wr_byte(8'hcd, 8'h9a);
        cmp = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        cmp = 1'b0;
        rd_chk(8'hca, 8'hbc);
        rd_chk(8'hcb, 8'h9a);
        rd_chk(8'hc8, 8'h92);
        check_byte({7'h00, irq}, 8'h01);
        irq_en = 1'b0;
        $display("test capture done");
    endtask

    initial begin
        repeat (20) @(negedge ref_clk_i);
        rst_i = 1'b0;
        t_reset();
        t_bits();
        t_wide();
        t_split();
        t_capture();
        summarize();
    end
endmodule

`default_nettype wire
